// ---- shared/ep_buf_consts.svh ----
// Offsets, field positions, reset values and counts for the endpoint buffer length block
`ifndef EP_BUF_CONSTS_SVH
`define EP_BUF_CONSTS_SVH
`define ADDR_MAX_PACKET_SIZE_CONFIG 8'h04
`define ADDR_PACKET_BYTE_COUNT      8'h1c
`define ADDR_DOUBLE_BUFFER_FILL     8'h1e
`define ADDR_ENDPOINT_INDEX         8'h2c
`define ADDR_ENDPOINT_DIR           8'h2e
`define ADDR_DOUBLE_BUF_ENABLE      8'h30
`define ADDR_CONTROL_FUNCTION       8'h28
`define FIFO_SIZE_MSB               10
`define TRANS_LSB                   11
`define TRANS_MSB                   12
`define MPS_WRITE_MASK              16'h1fff
`define CTRL_VALIDATE_BIT           3
`define CTRL_FORCE_CLEAR_BIT        4
`define RESET_PACKET_BYTE_COUNT     16'h0000
`define RESET_MPS                   16'h0000
`define NUM_ENDPOINTS               8
`define ENDPOINT_INDEX_WIDTH        3
`endif

// ---- shared/ep_buf_pkg.sv ----
// Types shared by the endpoint buffer length block
package ep_buf_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic [2:0]
  {
    FILL_IDLE   = 3'b001,
    FILL_ACTIVE = 3'b010,
    FILL_DONE   = 3'b100
  } fill_state_t;
endpackage

// ---- shared/ep_tx_if.sv ----
// Per-endpoint transmit validation signals between top and counter
`timescale 1ns/1ps
`default_nettype none
interface ep_tx_if;
  logic        write_pulse;
  logic [1:0]  write_bytes;
  logic        is_pio;
  logic        in_dir;
  logic [15:0] limit;
  logic        force_validate;
  logic        clear;
  logic        validated;
  modport top (output write_pulse, write_bytes, is_pio, in_dir, limit, force_validate, clear, input validated);
  modport ctr (input write_pulse, write_bytes, is_pio, in_dir, limit, force_validate, clear, output validated);
endinterface
`default_nettype wire

// ---- hdl/ep_tx_counter.sv ----
// Per-endpoint transmit byte counter that validates full or short packets
`timescale 1ns/1ps
`default_nettype none
`include "ep_buf_consts.svh"
module ep_tx_counter
  import ep_buf_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic arst_n,
  // Control
  ep_tx_if.ctr      tx
);
  word_t       written;
  fill_state_t state;
  word_t       sum;

  always_comb
  begin
    sum = written + {14'h0000, tx.write_bytes};
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      written <= 16'h0000;
      state   <= FILL_IDLE;
    end
    else if (tx.clear)
    begin
      written <= 16'h0000;
      state   <= FILL_IDLE;
    end
    else
    begin
      case (state)
        FILL_IDLE, FILL_ACTIVE:
        begin
          if (tx.force_validate && tx.in_dir)
          begin
            state   <= FILL_DONE;
            written <= 16'h0000;
          end
          else if (tx.write_pulse && tx.in_dir && tx.is_pio)
          begin
            if (tx.limit != 16'h0000 && sum >= tx.limit)
            begin
              state   <= FILL_DONE;
              written <= 16'h0000;
            end
            else
            begin
              state   <= FILL_ACTIVE;
              written <= sum;
            end
          end
        end
        FILL_DONE:
        begin
          state <= FILL_IDLE;
        end
        default:
        begin
          state <= FILL_IDLE;
        end
      endcase
    end
  end

  assign tx.validated = (state == FILL_DONE);
endmodule // ep_tx_counter
`default_nettype wire

// ---- hdl/endpoint_buffer_length_status.sv ----
// Packet byte count, fill status and max packet size registers for data endpoints
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "ep_buf_consts.svh"
module endpoint_buffer_length_status
  import ep_buf_pkg::*;
#(
  parameter int NUM_EP = `NUM_ENDPOINTS
)
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        usb_bus_reset,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // FIFO write side, from data port or DMA
  input  wire logic        fifo_wr,
  input  wire logic [1:0]  fifo_wr_bytes,
  input  wire logic        fifo_wr_dma,
  input  wire logic [2:0]  fifo_wr_ep,
  // Receive side, from packet engine
  input  wire logic        rx_ack,
  input  wire logic [2:0]  rx_ep,
  input  wire logic [15:0] rx_len,
  // Buffer occupancy, two bits per endpoint
  input  wire logic [2*NUM_EP-1:0] buf_full,
  // Read data word from FIFO and its odd-end flag
  input  wire logic [15:0] fifo_rdata,
  input  wire logic        fifo_rdata_odd,
  // Results
  output logic [NUM_EP-1:0] tx_validate,
  output logic [NUM_EP-1:0] rx_force_clear,
  output logic [15:0]       port_rdata,
  output logic [1:0]        transactions_per_microframe,
  output logic              hs_multi_enable
);
  word_t             packet_byte_count [NUM_EP];
  logic [12:0]       max_packet_size_config;
  logic [2:0]        ep_index;
  logic [NUM_EP-1:0] ep_dir_in;
  logic [NUM_EP-1:0] ep_double_buf;
  logic              explicit_validate_bit;
  logic              force_rx_clear_bit;
  logic [NUM_EP-1:0] validated;
  logic              bus_clear;
  word_t             next_rdata;
  logic [1:0]        fill_field;
  logic              mps_wr;
  logic              count_wr;

  // USB bus reset clears counts and size just like a hardware reset
  assign bus_clear = usb_bus_reset;
  // Control function bits act as one-cycle strokes; nothing is stored
  assign explicit_validate_bit = reg_wr && reg_addr == `ADDR_CONTROL_FUNCTION && reg_wdata[`CTRL_VALIDATE_BIT];
  assign force_rx_clear_bit = reg_wr && reg_addr == `ADDR_CONTROL_FUNCTION && reg_wdata[`CTRL_FORCE_CLEAR_BIT];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  // One endpoint's slot in a three-bit endpoint selector
  function automatic logic ep_match(input logic [2:0] sel, input int unsigned n);
    ep_match = (sel == 3'(n));
  endfunction

  assign mps_wr   = reg_wr && hit(reg_addr, `ADDR_MAX_PACKET_SIZE_CONFIG);
  assign count_wr = reg_wr && hit(reg_addr, `ADDR_PACKET_BYTE_COUNT);

  // Endpoint index used by all indexed registers
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ep_index <= 3'h0;
    end
    else if (reg_wr && hit(reg_addr, `ADDR_ENDPOINT_INDEX))
    begin
      ep_index <= reg_wdata[2:0];
    end
  end

  // Direction mask, one bit per endpoint, 1 for IN
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ep_dir_in <= '0;
    end
    else if (reg_wr && hit(reg_addr, `ADDR_ENDPOINT_DIR))
    begin
      ep_dir_in <= reg_wdata[NUM_EP-1:0];
    end
  end

  // Double-buffer mask, one bit per endpoint
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ep_double_buf <= '0;
    end
    else if (reg_wr && hit(reg_addr, `ADDR_DOUBLE_BUF_ENABLE))
    begin
      ep_double_buf <= reg_wdata[NUM_EP-1:0];
    end
  end

  // Max packet size register
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      max_packet_size_config <= 13'h0000;
    end
    else if (bus_clear)
    begin
      max_packet_size_config <= 13'h0000;
    end
    else if (mps_wr)
    begin
      max_packet_size_config <= reg_wdata[12:0];
    end
  end

  // Per-endpoint byte counts and validation counters
  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++)
    begin : g_ep
      // Each data endpoint owns a transmit counter
      ep_tx_if tx ();
      assign tx.write_pulse    = fifo_wr && ep_match(fifo_wr_ep, g) && g != 0;
      assign tx.write_bytes    = fifo_wr_bytes;
      assign tx.is_pio         = !fifo_wr_dma;
      assign tx.in_dir         = ep_dir_in[g];
      assign tx.limit          = packet_byte_count[g];
      assign tx.force_validate = explicit_validate_bit && ep_match(ep_index, g);
      assign tx.clear          = bus_clear;
      assign validated[g]      = tx.validated;

      ep_tx_counter u_ctr
      (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .tx      (tx)
      );

      // Priority: bus reset, received length, size reload, software write, restore
      always_ff @(posedge clk_sys or negedge arst_n)
      begin
        if (!arst_n)
        begin
          packet_byte_count[g] <= `RESET_PACKET_BYTE_COUNT;
        end
        else if (bus_clear)
        begin
          packet_byte_count[g] <= `RESET_PACKET_BYTE_COUNT;
        end
        else if (rx_ack && ep_match(rx_ep, g) && !ep_dir_in[g])
        begin
          packet_byte_count[g] <= rx_len;
        end
        else if (mps_wr && g != 0)
        begin
          packet_byte_count[g] <= {5'h00, reg_wdata[`FIFO_SIZE_MSB:0]};
        end
        else if (count_wr && ep_match(ep_index, g))
        begin
          packet_byte_count[g] <= reg_wdata;
        end
        // restore full size after short packet
        else if (validated[g] && g != 0)
        begin
          packet_byte_count[g] <= {5'h00, max_packet_size_config[`FIFO_SIZE_MSB:0]};
        end
      end
    end
  endgenerate

  // fill field for double-buffered data endpoints
  always_comb
  begin
    fill_field = 2'b00;
    if (ep_index != 3'h0 && ep_double_buf[ep_index])
    begin
      fill_field = buf_full[2*ep_index +: 2];
    end
  end

  // Read mux; reserved and unmapped addresses read zero
  always_comb
  begin
    next_rdata = 16'h0000;
    case (reg_addr)
      `ADDR_MAX_PACKET_SIZE_CONFIG: next_rdata = {3'h0, max_packet_size_config};
      `ADDR_PACKET_BYTE_COUNT:      next_rdata = packet_byte_count[ep_index];
      `ADDR_DOUBLE_BUFFER_FILL:     next_rdata = {14'h0000, fill_field};
      `ADDR_ENDPOINT_INDEX:         next_rdata = {13'h0000, ep_index};
      default:                      next_rdata = 16'h0000;
    endcase
  end

  // Read data stand one cycle, zero otherwise
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata <= 16'h0000;
    end
    else if (reg_rd)
    begin
      reg_rdata <= next_rdata;
    end
    else
    begin
      reg_rdata <= 16'h0000;
    end
  end

  // Validation strobes, one cycle each
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_validate <= '0;
    end
    else
    begin
      tx_validate <= validated;
    end
  end

  // Receive clear strobe for the indexed endpoint
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_force_clear <= '0;
    end
    else
    begin
      rx_force_clear <= force_rx_clear_bit ? (NUM_EP)'(1) << ep_index : '0;
    end
  end

  // odd last byte in low lane
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      port_rdata <= 16'h0000;
    end
    else
    begin
      port_rdata <= fifo_rdata_odd ? {8'h00, fifo_rdata[7:0]} : fifo_rdata;
    end
  end

  // 00 means one packet per microframe
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      transactions_per_microframe <= 2'b00;
      hs_multi_enable             <= 1'b0;
    end
    else
    begin
      transactions_per_microframe <= max_packet_size_config[`TRANS_MSB:`TRANS_LSB];
      hs_multi_enable             <= max_packet_size_config[`TRANS_MSB:`TRANS_LSB] != 2'b00;
    end
  end
endmodule // endpoint_buffer_length_status
`default_nettype wire

// ---- bench/ep_buf_asserts.sv ----
// Port-level checks of the endpoint buffer length block
`timescale 1ns/1ps
`default_nettype none
`include "ep_buf_consts.svh"
module ep_buf_chk
  import ep_buf_pkg::*;
#(
  parameter int NUM_EP = `NUM_ENDPOINTS
)
(
  // Clock and reset
  input wire logic                clk_sys,
  input wire logic                arst_n,
  input wire logic                usb_bus_reset,
  // Register port
  input wire logic [7:0]          reg_addr,
  input wire logic [15:0]         reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [15:0]         reg_rdata,
  // Status and data
  input wire logic [2*NUM_EP-1:0] buf_full,
  input wire logic [15:0]         fifo_rdata,
  input wire logic                fifo_rdata_odd,
  input wire logic [15:0]         port_rdata,
  input wire logic [1:0]          transactions_per_microframe,
  input wire logic                hs_multi_enable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic [2:0]        idx;
  logic [NUM_EP-1:0] dbl;
  wire logic mps_wr = reg_wr && reg_addr == `ADDR_MAX_PACKET_SIZE_CONFIG;
  // Shadow of the index and double-buffer mask
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      idx <= 3'h0;
      dbl <= '0;
    end
    else if (reg_wr && reg_addr == `ADDR_ENDPOINT_INDEX)
      idx <= reg_wdata[2:0];
    else if (reg_wr && reg_addr == `ADDR_DOUBLE_BUF_ENABLE)
      dbl <= reg_wdata[NUM_EP-1:0];
  fill_read_a: assert property (reg_rd && reg_addr == `ADDR_DOUBLE_BUFFER_FILL |=>
    reg_rdata == {14'h0, (idx != 3'h0 && dbl[idx]) ? $past(buf_full[2*idx +: 2]) : 2'h0}) else $error("fill read");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
    else $error("read data outside read slot");
  unmapped_read_a: assert property (reg_rd && reg_addr[7:6] != 2'h0 |=> reg_rdata == 16'h0)
    else $error("unmapped read nonzero");
  mps_reserved_a: assert property (reg_rd && reg_addr == `ADDR_MAX_PACKET_SIZE_CONFIG |=> reg_rdata[15:13] == 3'h0)
    else $error("reserved size bits set");
  trans_copy_a: assert property ((mps_wr && !usb_bus_reset) ##1 (!mps_wr && !usb_bus_reset) ##1 !usb_bus_reset
    |-> transactions_per_microframe == $past(reg_wdata[12:11], 2)) else $error("transaction count wrong");
  multi_enable_a: assert property (hs_multi_enable == (transactions_per_microframe != 2'h0))
    else $error("multi enable mismatch");
  bus_clear_a: assert property (usb_bus_reset [*2] |=> transactions_per_microframe == 2'h0)
    else $error("bus reset left transactions");
  port_odd_a: assert property (fifo_rdata_odd |=> port_rdata == {8'h0, $past(fifo_rdata[7:0])})
    else $error("odd byte lane wrong");
  port_even_a: assert property (!fifo_rdata_odd |=> port_rdata == $past(fifo_rdata))
    else $error("data word wrong");
  cover property (mps_wr);
  cover property (reg_rd && reg_addr == `ADDR_DOUBLE_BUFFER_FILL);
  cover property (usb_bus_reset);
endmodule // ep_buf_chk
bind endpoint_buffer_length_status ep_buf_chk #(.NUM_EP(NUM_EP)) u_ep_buf_chk (.*);
`default_nettype wire

// ---- bench/ep_mcu_model.sv ----
// Microcontroller model on the register port
`timescale 1ns/1ps
`default_nettype none
`include "ep_buf_consts.svh"
module ep_mcu_model
  import ep_buf_pkg::*;
(
  // Clock
  input  wire logic   clk_sys,
  // Register port
  output logic [7:0]  reg_addr = 8'h00,
  output word_t       reg_wdata = 16'h0,
  output logic        reg_wr = 1'b0,
  output logic        reg_rd = 1'b0,
  input  wire word_t  reg_rdata
);
  task automatic wr(input logic [7:0] a, input word_t d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  // Read strobe held one cycle; data taken 1 ns after the edge that registers it
  task automatic rd(input logic [7:0] a, output word_t d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic idx_rd(input logic [2:0] ep, input logic [7:0] a, output word_t d);
    wr(`ADDR_ENDPOINT_INDEX, {13'h0, ep});
    rd(a, d);
  endtask
endmodule // ep_mcu_model
`default_nettype wire

// ---- bench/tb_endpoint_buffer_length_status.sv ----
// Self-checking bench for the endpoint buffer length block
`timescale 1ns/1ps
`default_nettype none
`include "ep_buf_consts.svh"
module tb_endpoint_buffer_length_status
  import ep_buf_pkg::*;
;
  logic        clk_sys = 1'b0, arst_n = 1'b0, usb_bus_reset = 1'b0, reg_wr, reg_rd, hs_multi_enable;
  logic        fifo_wr = 1'b0, fifo_wr_dma = 1'b0, rx_ack = 1'b0, fifo_rdata_odd = 1'b0;
  logic [7:0]  reg_addr, tx_validate, rx_force_clear;
  logic [1:0]  fifo_wr_bytes = 2'h2, transactions_per_microframe;
  logic [2:0]  fifo_wr_ep = 3'h2, rx_ep = 3'h0;
  word_t       reg_wdata, reg_rdata, port_rdata, rx_len = 16'h0, fifo_rdata = 16'h0;
  logic [15:0] buf_full = 16'h0;
  int          n_fail = 0, num_checks = 0, vcnt = 0;
  endpoint_buffer_length_status u_endpoint_buffer_length_status (.*);
  ep_mcu_model u_ep_mcu_model (.*);
  always #12.5 clk_sys = ~clk_sys;
  // Pulses on endpoint 2 count once, anything else counts as a stray
  always @(posedge clk_sys)
    if (arst_n)
      vcnt += (tx_validate === 8'h04) ? 1 : ((tx_validate === 8'h00) ? 0 : 100);
  task automatic chk(input word_t g, input word_t e);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [2:0] ep, input logic [7:0] a, input word_t e);
    word_t d;
    u_ep_mcu_model.idx_rd(ep, a, d);
    chk(d, e);
  endtask
  task automatic fw(input int n, input logic dma);
    @(posedge clk_sys);
    fifo_wr     <= 1'b1;
    fifo_wr_dma <= dma;
    repeat (n) @(posedge clk_sys);
    fifo_wr     <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic t_mps;
    rc(3'h3, `ADDR_PACKET_BYTE_COUNT, 16'h0);
    rc(3'h3, `ADDR_MAX_PACKET_SIZE_CONFIG, 16'h0);
    rc(3'h3, 8'h50, 16'h0);
    u_ep_mcu_model.wr(`ADDR_MAX_PACKET_SIZE_CONFIG, 16'hf840);
    rc(3'h1, `ADDR_MAX_PACKET_SIZE_CONFIG, 16'h1840);
    rc(3'h7, `ADDR_PACKET_BYTE_COUNT, 16'h0040);
    rc(3'h0, `ADDR_PACKET_BYTE_COUNT, 16'h0000);
    chk({14'h0, transactions_per_microframe}, 16'h3);
    chk({15'h0, hs_multi_enable}, 16'h1);
  endtask
  task automatic t_tx;
    u_ep_mcu_model.wr(`ADDR_ENDPOINT_DIR, 16'h00de);
    u_ep_mcu_model.wr(`ADDR_MAX_PACKET_SIZE_CONFIG, 16'h0040);
    fw(31, 1'b0);
    chk(16'(vcnt), 16'h0);
    fw(1, 1'b0);
    chk(16'(vcnt), 16'h1);
    chk({15'h0, hs_multi_enable}, 16'h0);
    rc(3'h2, `ADDR_PACKET_BYTE_COUNT, 16'h0040);
    u_ep_mcu_model.wr(`ADDR_PACKET_BYTE_COUNT, 16'h003e);
    fw(31, 1'b0);
    chk(16'(vcnt), 16'h2);
    rc(3'h2, `ADDR_PACKET_BYTE_COUNT, 16'h0040);
    u_ep_mcu_model.wr(`ADDR_PACKET_BYTE_COUNT, 16'h003e);
    fw(31, 1'b1);
    chk(16'(vcnt), 16'h2);
    u_ep_mcu_model.wr(`ADDR_CONTROL_FUNCTION, 16'h0008);
    repeat (4) @(posedge clk_sys);
    chk(16'(vcnt), 16'h3);
    u_ep_mcu_model.wr(`ADDR_CONTROL_FUNCTION, 16'h0010);
    @(posedge clk_sys);
    chk({8'h0, rx_force_clear}, 16'h0004);
    u_ep_mcu_model.wr(`ADDR_PACKET_BYTE_COUNT, 16'h0003);
    fw(1, 1'b0);
    fifo_wr_bytes <= 2'h1;
    fw(1, 1'b0);
    fifo_wr_bytes <= 2'h2;
    chk(16'(vcnt), 16'h4);
  endtask
  task automatic t_rx;
    @(posedge clk_sys);
    rx_ep          <= 3'h5;
    rx_len         <= 16'h01ff;
    rx_ack         <= 1'b1;
    fifo_rdata     <= 16'habcd;
    fifo_rdata_odd <= 1'b1;
    @(posedge clk_sys);
    rx_ep          <= 3'h1;
    fifo_rdata_odd <= 1'b0;
    @(posedge clk_sys);
    rx_ack         <= 1'b0;
    rc(3'h5, `ADDR_PACKET_BYTE_COUNT, 16'h01ff);
    rc(3'h1, `ADDR_PACKET_BYTE_COUNT, 16'h0040);
  endtask
  task automatic t_fill;
    u_ep_mcu_model.wr(`ADDR_DOUBLE_BUF_ENABLE, 16'h0009);
    for (int c = 0; c < 4; c++)
    begin
      @(posedge clk_sys);
      buf_full <= 16'h0303 | 16'(c << 6);
      rc(3'h3, `ADDR_DOUBLE_BUFFER_FILL, 16'(c));
    end
    rc(3'h4, `ADDR_DOUBLE_BUFFER_FILL, 16'h0);
    rc(3'h0, `ADDR_DOUBLE_BUFFER_FILL, 16'h0);
  endtask
  task automatic t_bus;
    u_ep_mcu_model.wr(`ADDR_MAX_PACKET_SIZE_CONFIG, 16'h1840);
    @(posedge clk_sys);
    usb_bus_reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    usb_bus_reset <= 1'b0;
    rc(3'h5, `ADDR_PACKET_BYTE_COUNT, 16'h0);
    rc(3'h5, `ADDR_MAX_PACKET_SIZE_CONFIG, 16'h0);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_mps;
    t_tx;
    t_rx;
    t_fill;
    t_bus;
    results;
  end
endmodule // tb_endpoint_buffer_length_status
`default_nettype wire
